//--- pkg/gcm_map.vh
/*
  register offsets, field positions, reset values and timing counts for the
  global clock and memory control register bank. assumes byte addressing on a
  32-bit classic wishbone bus.
*/
`ifndef GCM_MAP_VH
`define GCM_MAP_VH

`define GCM_ADR_CLK_DIV 8'h18
`define GCM_ADR_CLK_GATE0 8'h24
`define GCM_ADR_MEM_CLK 8'h28
`define GCM_ADR_ZEROIZE 8'h2C
`define GCM_ADR_RSVD_A 8'h34
`define GCM_ADR_RSVD_C 8'h38
`define GCM_ADR_SYS_STAT 8'h40
`define GCM_ADR_PERIPH_RST1 8'h44
`define GCM_ADR_CLK_GATE1 8'h48
`define GCM_ADR_WAKE_EVT 8'h4C
`define GCM_ADR_REVISION 8'h50
`define GCM_ADR_STAT_IE 8'h54

`define GCM_GATE0_MASK 32'h1003A6E1
`define GCM_GATE1_MASK 32'h00000808
`define GCM_MEMCLK_MASK 32'h00001F07
`define GCM_FWS_RESET 3'h5
`define GCM_CLR_WORDS 16'h0100
`define GCM_CACHE_CLR_WORDS 16'h0040
`define GCM_TWB_RST_CYCLES 4'h8
`define GCM_TWB_BIT 28
`define GCM_ICACHE_LS_BIT 12
`define GCM_ZERO_CACHE_BIT 1
`define GCM_ZERO_DATA_BIT 0
`define GCM_EVT_PIN_BIT 1
`define GCM_EVT_DMA_BIT 0

`endif

//--- core/gcm_regs.v
/*
  global clock and memory control register bank: clock gates, always-on
  divider, ram light sleep, flash wait states, zeroize sequencer, second
  peripheral reset, wake events, debug lock status and revision.
  assumes a classic wishbone master on clk_i; rst_i is the combined
  power-on/system/watchdog reset; pin and lock inputs are asynchronous.
*/
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
`include "gcm_map.vh"

module gcm_regs #(
  parameter [15:0] REVISION_ID = 16'h0010, // arbitrary value
  parameter [15:0] DATA_CLR_WORDS = `GCM_CLR_WORDS,
  parameter [15:0] CACHE_CLR_WORDS = `GCM_CACHE_CLR_WORDS
) (
  input wire clk_i, // system clock
  input wire rst_i, // power-on/system/watchdog reset
  input wire wb_cyc_i, // bus cycle
  input wire wb_stb_i, // bus strobe
  input wire wb_we_i, // write enable
  input wire [7:0] wb_adr_i, // byte address
  input wire [3:0] wb_sel_i, // byte lanes
  input wire [31:0] wb_dat_i, // write data
  output reg [31:0] wb_dat_o, // read data
  output reg wb_ack_o, // acknowledge
  input wire debug_lock_i, // factory lock fuse
  input wire port_pin8_i, // port pin 8 level
  input wire dma_count_to_zero_i, // dma count-to-zero pulse
  output reg [1:0] always_on_domain_div_o, // always-on clock divider
  output reg [31:0] periph_clock_off_o, // per-peripheral clock off
  output reg [31:0] periph_access_block_o, // block peripheral bus access
  output reg icache_clock_off_o, // cache clock off
  output reg flash_ctrl_clock_off_o, // flash controller clock off
  output reg [4:0] retain_no_access_state_o, // light sleep: cache, ram3..0
  output reg [2:0] flash_wait_states_o, // flash wait states
  output reg data_ram_clear_we_o, // data ram zero write strobe
  output reg cache_clear_we_o, // cache ram zero write strobe
  output reg [15:0] clear_addr_o, // clear word address
  output reg twowire_b_reset_o, // twowire b reset
  output reg processor_receive_event_o, // wake event: pin level or dma pulse
  output reg debug_refuse_o, // refuse serial-wire debug
  output reg status_irq_o // system status interrupt
);

  reg lock_meta_reg, lock_sync_reg;
  reg pin_meta_reg, pin_sync_reg;
  reg dma_meta_reg, dma_sync_reg, dma_prev_reg;
  reg [31:0] gate0_reg, gate1_reg, memclk_reg;
  reg [1:0] div_reg;
  reg data_clr_reg, cache_clr_reg;
  reg [15:0] data_cnt_reg, cache_cnt_reg;
  reg twb_rst_reg;
  reg [3:0] twb_cnt_reg;
  reg [1:0] evt_en_reg;
  reg stat_ie_reg;
  reg [31:0] rd_next;
  reg [31:0] wmask;
  reg [31:0] sel_mask;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  integer i;

  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      sel_mask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
    wmask = sel_mask;
  end

  // asynchronous inputs pass two flops
  always @(posedge clk_i) begin
    lock_meta_reg <= debug_lock_i;
    lock_sync_reg <= lock_meta_reg;
    pin_meta_reg <= port_pin8_i;
    pin_sync_reg <= pin_meta_reg;
    dma_meta_reg <= dma_count_to_zero_i;
    dma_sync_reg <= dma_meta_reg;
    dma_prev_reg <= dma_sync_reg;
  end

  always @* begin
    rd_next = 32'h00000000;
    case (wb_adr_i)
      `GCM_ADR_CLK_DIV: rd_next = {30'h00000000, div_reg};
      `GCM_ADR_CLK_GATE0: rd_next = gate0_reg;
      `GCM_ADR_MEM_CLK: rd_next = memclk_reg;
      `GCM_ADR_ZEROIZE: rd_next = {30'h00000000, cache_clr_reg, data_clr_reg};
      `GCM_ADR_SYS_STAT: rd_next = {31'h00000000, lock_sync_reg};
      `GCM_ADR_PERIPH_RST1: rd_next = {31'h00000000, twb_rst_reg};
      `GCM_ADR_CLK_GATE1: rd_next = gate1_reg;
      `GCM_ADR_WAKE_EVT: rd_next = {30'h00000000, evt_en_reg};
      `GCM_ADR_REVISION: rd_next = {16'h0000, REVISION_ID};
      `GCM_ADR_STAT_IE: rd_next = {31'h00000000, stat_ie_reg};
      default: rd_next = 32'h00000000;
    endcase
  end

  // bus slave: ack one cycle after strobe, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_next : 32'h00000000;
    end
  end

  // control registers, reset only by rst_i
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 2'h0;
      gate0_reg <= 32'h00000000;
      gate1_reg <= 32'h00000000;
      memclk_reg <= {29'h00000000, `GCM_FWS_RESET};
      evt_en_reg <= 2'h0;
      stat_ie_reg <= 1'b0;
    end else if (wr) begin
      case (wb_adr_i)
        `GCM_ADR_CLK_DIV: div_reg <= (wb_dat_i[1:0] & wmask[1:0]) | (div_reg & ~wmask[1:0]);
        `GCM_ADR_CLK_GATE0: gate0_reg <= ((wb_dat_i & wmask) | (gate0_reg & ~wmask)) & `GCM_GATE0_MASK;
        `GCM_ADR_CLK_GATE1: gate1_reg <= ((wb_dat_i & wmask) | (gate1_reg & ~wmask)) & `GCM_GATE1_MASK;
        `GCM_ADR_MEM_CLK: memclk_reg <= ((wb_dat_i & wmask) | (memclk_reg & ~wmask)) & `GCM_MEMCLK_MASK;
        `GCM_ADR_WAKE_EVT: evt_en_reg <= (wb_dat_i[1:0] & wmask[1:0]) | (evt_en_reg & ~wmask[1:0]);
        `GCM_ADR_STAT_IE: stat_ie_reg <= wmask[0] ? wb_dat_i[0] : stat_ie_reg;
        default: div_reg <= div_reg;
      endcase
    end
  end

  wire zwr = wr & (wb_adr_i == `GCM_ADR_ZEROIZE) & wb_sel_i[0];
  wire start_data = zwr & wb_dat_i[`GCM_ZERO_DATA_BIT];
  wire start_cache = zwr & wb_dat_i[`GCM_ZERO_CACHE_BIT];

  // zeroize sequencers walk every word, then self-clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      data_clr_reg <= 1'b0;
      cache_clr_reg <= 1'b0;
      data_cnt_reg <= 16'h0000;
      cache_cnt_reg <= 16'h0000;
    end else begin
      if (start_data && !data_clr_reg) begin
        data_clr_reg <= 1'b1;
        data_cnt_reg <= 16'h0000;
      end else if (data_clr_reg) begin
        data_cnt_reg <= data_cnt_reg + 16'h0001;
        if (data_cnt_reg == DATA_CLR_WORDS - 16'h0001) begin
          data_clr_reg <= 1'b0;
        end
      end
      if (start_cache && !cache_clr_reg) begin
        cache_clr_reg <= 1'b1;
        cache_cnt_reg <= 16'h0000;
      end else if (cache_clr_reg) begin
        cache_cnt_reg <= cache_cnt_reg + 16'h0001;
        if (cache_cnt_reg == CACHE_CLR_WORDS - 16'h0001) begin
          cache_clr_reg <= 1'b0;
        end
      end
    end
  end

  // twowire b reset pulse, bit self-clears when done
  always @(posedge clk_i) begin
    if (rst_i) begin
      twb_rst_reg <= 1'b0;
      twb_cnt_reg <= 4'h0;
    end else if (wr && wb_adr_i == `GCM_ADR_PERIPH_RST1 && wb_sel_i[0] && wb_dat_i[0] && !twb_rst_reg) begin
      twb_rst_reg <= 1'b1;
      twb_cnt_reg <= 4'h0;
    end else if (twb_rst_reg) begin
      twb_cnt_reg <= twb_cnt_reg + 4'h1;
      if (twb_cnt_reg == `GCM_TWB_RST_CYCLES - 4'h1) begin
        twb_rst_reg <= 1'b0;
      end
    end
  end

  // outputs, all registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      always_on_domain_div_o <= 2'h0;
      periph_clock_off_o <= 32'h00000000;
      periph_access_block_o <= 32'h00000000;
      icache_clock_off_o <= 1'b0;
      flash_ctrl_clock_off_o <= 1'b0;
      retain_no_access_state_o <= 5'h00;
      flash_wait_states_o <= `GCM_FWS_RESET;
      data_ram_clear_we_o <= 1'b0;
      cache_clear_we_o <= 1'b0;
      clear_addr_o <= 16'h0000;
      twowire_b_reset_o <= 1'b0;
      processor_receive_event_o <= 1'b0;
      debug_refuse_o <= 1'b0;
      status_irq_o <= 1'b0;
    end else begin
      always_on_domain_div_o <= div_reg;
      // gating stops the clock and blocks bus access; peripheral state is held
      periph_clock_off_o <= gate0_reg;
      periph_access_block_o <= gate0_reg | ({31'h00000000, twb_rst_reg} << `GCM_TWB_BIT);
      icache_clock_off_o <= gate1_reg[11];
      flash_ctrl_clock_off_o <= gate1_reg[3];
      retain_no_access_state_o <= memclk_reg[`GCM_ICACHE_LS_BIT:8];
      flash_wait_states_o <= memclk_reg[2:0];
      data_ram_clear_we_o <= data_clr_reg;
      cache_clear_we_o <= cache_clr_reg;
      clear_addr_o <= data_clr_reg ? data_cnt_reg : cache_cnt_reg;
      twowire_b_reset_o <= twb_rst_reg;
      processor_receive_event_o <= (evt_en_reg[`GCM_EVT_PIN_BIT] & pin_sync_reg) |
        (evt_en_reg[`GCM_EVT_DMA_BIT] & dma_sync_reg & ~dma_prev_reg);
      debug_refuse_o <= lock_sync_reg;
      status_irq_o <= stat_ie_reg & lock_sync_reg;
    end
  end

endmodule // gcm_regs

//--- bench/gcm_regs_assertions.sv
/* checker for gcm_regs, bound to every instance after the module.
   assumes rst_i synchronous active high and a classic wishbone master. */
`timescale 1ns/10ps
`include "gcm_map.vh"
module gcm_regs_check #(
  parameter [15:0] DATA_CLR_WORDS = `GCM_CLR_WORDS
) (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  input wire wb_we_i, // write
  input wire [7:0] wb_adr_i, // address
  input wire [31:0] wb_dat_o, // read data
  input wire wb_ack_o, // ack
  input wire debug_lock_i, // lock fuse
  input wire [2:0] flash_wait_states_o, // wait states
  input wire data_ram_clear_we_o, // clear strobe
  input wire [15:0] clear_addr_o, // clear address
  input wire twowire_b_reset_o, // twowire reset
  input wire processor_receive_event_o, // wake
  input wire debug_refuse_o, // debug refused
  input wire status_irq_o // interrupt
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
  chk_rev_upper_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `GCM_ADR_REVISION
    |-> wb_dat_o[31:16] == 16'h0) else $error("revision upper bits set");
  chk_fws_reset_five: assert property ($fell(rst_i) |-> flash_wait_states_o == `GCM_FWS_RESET)
    else $error("wait states not five");
  chk_twb_reset_len: assert property ($rose(twowire_b_reset_o) |-> twowire_b_reset_o [*8] ##1 !twowire_b_reset_o)
    else $error("twowire reset length");
  chk_clear_addr_step: assert property (data_ram_clear_we_o && $past(data_ram_clear_we_o)
    |-> clear_addr_o == $past(clear_addr_o) + 16'h1) else $error("clear address skip");
  chk_clear_end_word: assert property ($fell(data_ram_clear_we_o)
    |-> $past(clear_addr_o) == DATA_CLR_WORDS - 16'h1) else $error("clear ended early or late");
  chk_lock_refuses: assert property (debug_lock_i [*5] |-> debug_refuse_o) else $error("lock not refusing");
  chk_irq_needs_lock: assert property (status_irq_o |-> debug_refuse_o || $past(debug_refuse_o))
    else $error("irq without lock");
  cov_twb: cover property ($rose(twowire_b_reset_o));
  cov_clear: cover property ($fell(data_ram_clear_we_o));
  cov_wake: cover property ($rose(processor_receive_event_o));
  cov_irq: cover property ($rose(status_irq_o));
endmodule // gcm_regs_check
bind gcm_regs gcm_regs_check #(.DATA_CLR_WORDS(DATA_CLR_WORDS)) i_gcm_regs_check (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .debug_lock_i(debug_lock_i), .flash_wait_states_o(flash_wait_states_o),
  .data_ram_clear_we_o(data_ram_clear_we_o), .clear_addr_o(clear_addr_o), .twowire_b_reset_o(twowire_b_reset_o),
  .processor_receive_event_o(processor_receive_event_o), .debug_refuse_o(debug_refuse_o), .status_irq_o(status_irq_o));

//--- bench/gcm_regs_bench.sv
/* self-checking bench for gcm_regs over classic wishbone.
   assumes the checker is bound; clear lengths shortened to 8 words. */
`timescale 1ns/10ps
`include "gcm_map.vh"
`define CK(n, e, a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", n, e, a); end end
module gcm_regs_bench;
  localparam [15:0] REV = 16'h0010; // arbitrary value
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, lock, pin, dma, cache_on, flash_on, clr_we, twb, evt, refuse, irq;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, clk_off;
  logic [1:0] div;
  logic cclr;
  logic [4:0] lsleep;
  logic [2:0] fws;
  int n_mismatch = 0, n_checks = 0;
  gcm_regs #(.REVISION_ID(REV), .DATA_CLR_WORDS(16'h0008), .CACHE_CLR_WORDS(16'h0008)) i_gcm_regs (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .debug_lock_i(lock), .port_pin8_i(pin),
    .dma_count_to_zero_i(dma), .always_on_domain_div_o(div), .periph_clock_off_o(clk_off), .periph_access_block_o(),
    .icache_clock_off_o(cache_on), .flash_ctrl_clock_off_o(flash_on), .retain_no_access_state_o(lsleep),
    .flash_wait_states_o(fws), .data_ram_clear_we_o(clr_we), .cache_clear_we_o(cclr), .clear_addr_o(),
    .twowire_b_reset_o(twb), .processor_receive_event_o(evt), .debug_refuse_o(refuse), .status_irq_o(irq));
  initial begin
    clk_i = 0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CK("read", e, rd)
  endtask
  task automatic t_reset_values();
    logic [7:0] ad [12] = '{8'h18, 8'h24, 8'h28, 8'h2C, 8'h34, 8'h38, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54};
    `CK("fws", 3'h5, fws)
    `CK("irq rst", 1'b0, irq)
    foreach (ad[i]) rdchk(ad[i], ad[i] == 8'h28 ? 32'h5 : ad[i] == 8'h50 ? {16'h0, REV} : 32'h0);
  endtask
  task automatic t_read_write();
    bus(1'b1, 8'h18, 32'hFFFFFFFF);
    rdchk(8'h18, 32'h3);
    bus(1'b1, 8'h24, 32'hFFFFFFFF);
    rdchk(8'h24, `GCM_GATE0_MASK);
    bus(1'b1, 8'h48, 32'hFFFFFFFF);
    rdchk(8'h48, `GCM_GATE1_MASK);
    bus(1'b1, 8'h28, 32'hFFFFFFFF);
    rdchk(8'h28, `GCM_MEMCLK_MASK);
    bus(1'b1, 8'h50, 32'hFFFFFFFF);
    rdchk(8'h50, {16'h0, REV});
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    rdchk(8'h40, 32'h0);
    bus(1'b1, 8'h34, 32'hFFFFFFFF);
    rdchk(8'h34, 32'h0);
    `CK("div", 2'h3, div)
    `CK("gate0", `GCM_GATE0_MASK, clk_off)
    `CK("gate1", 2'h3, {cache_on, flash_on})
    `CK("sleep", 5'h1F, lsleep)
    `CK("fws", 3'h7, fws)
  endtask
  task automatic t_zeroize(input int b);
    bus(1'b1, 8'h2C, 32'h1 << b);
    rdchk(8'h2C, 32'h1 << b);
    `CK("data strobe", (b == 0), clr_we)
    `CK("cache strobe", (b == 1), cclr)
    repeat (12) @(posedge clk_i);
    rdchk(8'h2C, 32'h0);
  endtask
  task automatic t_twowire_reset();
    bus(1'b1, 8'h44, 32'h1);
    rdchk(8'h44, 32'h1);
    `CK("twb", 1'b1, twb)
    repeat (10) @(posedge clk_i);
    rdchk(8'h44, 32'h0);
  endtask
  task automatic t_wake();
    int seen = 0;
    bus(1'b1, 8'h4C, 32'h2);
    pin <= 1'b1;
    repeat (5) @(posedge clk_i);
    `CK("pin wake", 1'b1, evt)
    bus(1'b1, 8'h4C, 32'h1);
    repeat (5) @(posedge clk_i);
    `CK("pin masked", 1'b0, evt)
    pin <= 1'b0;
    dma <= 1'b1;
    repeat (8) begin
      @(posedge clk_i);
      seen += (evt === 1'b1);
    end
    `CK("dma wake", 1, seen)
  endtask
  task automatic t_lock_irq();
    lock <= 1'b1;
    bus(1'b1, 8'h54, 32'h1);
    repeat (6) @(posedge clk_i);
    `CK("irq", 1'b1, irq)
    `CK("refuse", 1'b1, refuse)
    rdchk(8'h40, 32'h1);
    bus(1'b1, 8'h54, 32'h0);
    repeat (3) @(posedge clk_i);
    `CK("irq off", 1'b0, irq)
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, lock, pin, dma} = 7'h40;
    wb_adr_i = 8'h0;
    wb_dat_i = 32'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_read_write();
    t_zeroize(0);
    t_zeroize(1);
    t_twowire_reset();
    t_wake();
    t_lock_irq();
    lock <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    tally_and_finish();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish();
  end
endmodule // gcm_regs_bench
